/* core/sgl_pkg.sv */
// Package for the speaker gain and headroom limiter.
// Assumes a single 125 MHz clock and an APB register port.
package sgl_pkg;
  // ==================================================
  // Clock and sample-rate bands.
  // ==================================================
  localparam int MCLK_HZ = 125_000_000;
  localparam int RATE_HI_HZ = 64_000;   // At or above: fast filter.
  localparam int RATE_MID_HZ = 32_000;  // At or above: middle filter.
  localparam int RATE_HI_CYC = MCLK_HZ / RATE_HI_HZ;
  localparam int RATE_MID_CYC = MCLK_HZ / RATE_MID_HZ;
  // ==================================================
  // Register offsets (byte addresses).
  // ==================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VOL = 8'h04;
  localparam logic [7:0] OFS_GAIN = 8'h08;
  localparam logic [7:0] OFS_TRACK = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ==================================================
  // Field positions and reset values.
  // ==================================================
  localparam int CTRL_SAFE = 0;   // Protect level enable.
  localparam int CTRL_RISE = 1;   // Volume rise ramp enable.
  localparam int CTRL_FALL = 2;   // Volume fall ramp enable.
  localparam int CTRL_TRACK = 3;  // Headroom tracker enable.
  localparam int CTRL_MODE = 4;   // Limiter mode select.
  localparam int CTRL_PATH = 5;   // Speaker path on.
  localparam logic [5:0] CTRL_RST = 6'h01;
  localparam logic [6:0] VOL_RST = 7'h00;
  localparam logic [6:0] VOL_MUTE = 7'h7F;
  localparam logic [3:0] GAIN_RST = 4'h0;
  localparam int MARGIN_LSB = 0;
  localparam int CAP_LSB = 8;
  localparam logic [4:0] MARGIN_RST = 5'h08;
  localparam logic [4:0] MARGIN_MAX = 5'h10;
  localparam logic [3:0] CAP_RST = 4'h0E;
  localparam logic [3:0] CAP_MAX = 4'h0E;
  localparam int STAT_STICKY = 0;
  localparam int STAT_LIVE = 1;
  localparam int STAT_VOL_LSB = 8;
  // ==================================================
  // Levels in signed dB with 8 fraction bits.
  // ==================================================
  localparam int DB_PER_LOG2 = 1541;    // 6.0206 dB per octave.
  localparam int LOG2_PER_DB = 85;      // 0.1661 octave per dB, /512.
  localparam int FS_DB = 23 * DB_PER_LOG2;  // 2^23 sample full scale.
  localparam int DAC_FS_DB = 123;       // 0.48 dBV full scale.
  localparam int MV_TO_V_DB = 15360;    // 60 dB, millivolt to volt.
  localparam int MARGIN_DIV_DB = 8202;  // 20log10(40).
  localparam int MARGIN_BASE = 32;      // Factor is (32+code)/40.
  localparam int SCALE_MIN_DB = 6 * 256;
  localparam int SAFE_DB = -18 * 256;
  localparam int VOL_STEP_DB = 128;     // 0.5 dB.
endpackage

/* core/sgl_limiter.sv */
// Speaker gain and headroom limiter: volume, safe level, peak
// scaling and supply-tracking distortion limiter on mono samples.
// Assumes samples and supply readings are synchronous to mclk.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sgl_limiter #(
  parameter int SAMPLE_W = 24,
  parameter int SUPPLY_W = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sampleValid,
  input wire logic [SAMPLE_W-1:0] sampleIn,
  input wire logic supplyValid,
  input wire logic [SUPPLY_W-1:0] supplyCode,
  output logic outValid,
  output logic [SAMPLE_W-1:0] sampleOut,
  output logic [2:0] analogGainCode,
  output logic [1:0] dacFilterSel,
  output logic limiterActive
);

  // ==================================================
  // Log2 helper.
  // ==================================================
  // Leading-one position plus a linear mantissa: within about 0.5 dB,
  // which is ample for a limiter and costs no table.
  function automatic logic [12:0] log2q(input logic [23:0] x);
    int n;
    logic [23:0] y;
    n = 0;
    for (int i = 0; i < 24; i++) begin
      if (x[i]) begin
        n = i;
      end
    end
    y = x << (23 - n);
    log2q = {5'(n), y[22:15]};
  endfunction

  // Converts a magnitude, through its log2, into signed dB with 8 fraction bits.
  function automatic logic signed [19:0] dbOf(input logic [23:0] x);
    logic [23:0] p;
    p = 24'(24'(log2q(x)) * 24'(sgl_pkg::DB_PER_LOG2));
    dbOf = $signed({4'h0, p[23:8]});
  endfunction

  // ==================================================
  // Registers.
  // ==================================================
  logic [5:0] ctrl_q;        // Control bits.
  logic [6:0] vol_q;         // Requested volume code.
  logic [3:0] scale_q;       // Peak output scaling code.
  logic [4:0] margin_q;      // Supply margin code.
  logic [3:0] cap_q;         // Attenuation cap code.
  logic sticky_q;            // Limiter engaged, sticky.
  logic [6:0] curVol_q;      // Volume code being applied.
  logic [SUPPLY_W-1:0] supply_q;  // Latest supply reading.
  logic [31:0] prdata_q;     // Read data, loaded in setup.
  logic outValid_q;          // Output sample strobe.
  logic [SAMPLE_W-1:0] sampleOut_q;  // Output sample.
  logic [2:0] analog_q;      // Analog share of the scaling.
  logic [1:0] filt_q;        // Lowpass filter selection.
  logic [15:0] gap_q;        // Cycles since last sample.
  logic live_q;              // Limiter attenuating now.

  // ==================================================
  // APB decode.
  // ==================================================
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hitCtrl = (paddr == sgl_pkg::OFS_CTRL);
  wire hitVol = (paddr == sgl_pkg::OFS_VOL);
  wire hitGain = (paddr == sgl_pkg::OFS_GAIN);
  wire hitTrack = (paddr == sgl_pkg::OFS_TRACK);
  wire hitStat = (paddr == sgl_pkg::OFS_STATUS);
  wire hit = hitCtrl | hitVol | hitGain | hitTrack | hitStat;
  wire wrEn = access & pwrite & hit;
  // The status read clears on its access edge, where a set still wins.
  wire statRead = access & ~pwrite & hitStat;
  // Codes above the documented range are clamped on write.
  wire [4:0] marginWr = (pwdata[4:0] > sgl_pkg::MARGIN_MAX) ?
    sgl_pkg::MARGIN_MAX : pwdata[4:0];
  wire [3:0] capWr = (pwdata[11:8] > sgl_pkg::CAP_MAX) ?
    sgl_pkg::CAP_MAX : pwdata[11:8];
  wire [31:0] trackRd = {20'h0, cap_q, 3'h0, margin_q};
  wire [31:0] statRd = {17'h0, curVol_q, 6'h0, live_q, sticky_q};
  wire [31:0] rdMux =
    hitCtrl ? {26'h0, ctrl_q} :
    hitVol ? {25'h0, vol_q} :
    hitGain ? {28'h0, scale_q} :
    hitTrack ? trackRd :
    hitStat ? statRd : 32'h0;

  // The slave never inserts wait states.
  assign pready = 1'b1;
  // Unmapped addresses answer with an error in the access phase.
  assign pslverr = access & ~hit;
  assign prdata = prdata_q;

  // ==================================================
  // Control decode.
  // ==================================================
  wire safeOn = ctrl_q[sgl_pkg::CTRL_SAFE];
  wire riseRamp = ctrl_q[sgl_pkg::CTRL_RISE];
  wire fallRamp = ctrl_q[sgl_pkg::CTRL_FALL];
  wire trackOn = ctrl_q[sgl_pkg::CTRL_TRACK];
  wire modeFixed = ctrl_q[sgl_pkg::CTRL_MODE];
  wire pathOn = ctrl_q[sgl_pkg::CTRL_PATH];

  // ==================================================
  // Target peak and rotation point.
  // ==================================================
  // Product of supply and (32+code); divided by 40 in dB below.
  wire [5:0] marginFac = 6'(sgl_pkg::MARGIN_BASE) + {1'b0, margin_q};
  wire [23:0] tpoProd = 24'(supply_q * marginFac);
  // Maximum peak output in dBV: 0.48 plus 6..21 dB scaling.
  wire signed [19:0] mpoDb = 20'(sgl_pkg::DAC_FS_DB) +
    20'(sgl_pkg::SCALE_MIN_DB) + $signed({8'h0, scale_q, 8'h0});
  // Target attenuation relative to the maximum peak output.
  wire signed [19:0] tpoDb = dbOf(tpoProd) -
    20'(sgl_pkg::MARGIN_DIV_DB) - 20'(sgl_pkg::MV_TO_V_DB) - mpoDb;
  // Positive headroom never becomes gain; this is also the
  // rotation point, recomputed whenever supply or settings move.
  wire signed [19:0] rotDb = (tpoDb > 0) ? 20'sd0 : tpoDb;

  // ==================================================
  // Input level and limiter attenuation.
  // ==================================================
  wire sNeg = sampleIn[SAMPLE_W-1];
  wire [SAMPLE_W-1:0] sMag = sNeg ? (~sampleIn + 1'b1) : sampleIn;
  wire signed [19:0] inDb = dbOf(24'(sMag)) - 20'(sgl_pkg::FS_DB);
  // Infinite ratio: anything over the rotation point is pulled
  // back onto it; below it the sample passes unchanged.
  wire signed [19:0] rawAtt = (inDb > rotDb) ? (rotDb - inDb) : 20'sd0;
  wire signed [19:0] capDb = -$signed({7'h0, 5'(cap_q) + 5'h1, 8'h0});
  wire signed [19:0] cappedAtt = (rawAtt < capDb) ? capDb : rawAtt;
  // The fixed-level mode is not built here, so it attenuates
  // nothing; the limiter also rests while the tracker is off.
  wire limOn = trackOn & ~modeFixed;
  wire signed [19:0] limAtt = limOn ? cappedAtt : 20'sd0;
  // Any negative attenuation on this sample counts as engaged.
  wire limEngaged = limAtt < 0;

  // ==================================================
  // Total gain in dB.
  // ==================================================
  // The odd 1 dB of scaling is digital, the 2 dB steps analog.
  wire signed [19:0] digScale = scale_q[0] ? 20'sd256 : 20'sd0;
  wire signed [19:0] volDb =
    -$signed(20'(curVol_q * 8'(sgl_pkg::VOL_STEP_DB)));
  // Safe level replaces both volume and scaling.
  wire signed [19:0] gainDb = safeOn ?
    (20'(sgl_pkg::SAFE_DB) + limAtt) : (volDb + digScale + limAtt);
  wire muted = ~safeOn & (curVol_q == sgl_pkg::VOL_MUTE);

  // ==================================================
  // Gain from dB to linear.
  // ==================================================
  // Octaves = dB * 85 / 512; the integer part becomes a shift
  // and the fraction a linear mantissa of 1.0 to 2.0.
  wire signed [27:0] octFull = 28'(gainDb * 28'sd85);
  wire signed [27:0] oct = octFull >>> 9;
  wire signed [19:0] octInt = 20'(oct >>> 8);
  wire [7:0] octFrac = oct[7:0];
  wire signed [20:0] shRaw = 21'sd8 - 21'(octInt);
  wire [5:0] sh = (shRaw > 21'sd40) ? 6'd40 : 6'(shRaw);
  wire signed [9:0] mant = $signed({2'b01, octFrac});
  // The port is plain logic; the multiply must see it as signed or
  // negative samples would scale as huge positive ones.
  wire signed [SAMPLE_W-1:0] sIn = $signed(sampleIn);
  wire signed [SAMPLE_W+9:0] prod = sIn * mant;
  wire signed [SAMPLE_W+9:0] scaled = prod >>> sh;
  localparam logic signed [SAMPLE_W+9:0] POS_LIM =
    (SAMPLE_W+10)'((1 << (SAMPLE_W - 1)) - 1);
  localparam logic signed [SAMPLE_W+9:0] NEG_LIM = -POS_LIM - 1;
  // Saturate rather than wrap when the digital scaling adds gain.
  wire [SAMPLE_W-1:0] satOut =
    (scaled > POS_LIM) ? POS_LIM[SAMPLE_W-1:0] :
    (scaled < NEG_LIM) ? NEG_LIM[SAMPLE_W-1:0] :
    scaled[SAMPLE_W-1:0];

  // ==================================================
  // Volume ramp target.
  // ==================================================
  // Start-up and shut-down are ramps to and from mute.
  wire [6:0] volTarget = pathOn ? vol_q : sgl_pkg::VOL_MUTE;
  wire rampDown = curVol_q < volTarget;
  wire rampUp = curVol_q > volTarget;
  // A ramp moves one step per sample, so slow rates ramp slowly.
  // Without a ramp enable the target is taken in one step.
  wire [6:0] volNext =
    rampDown ? (fallRamp ? curVol_q + 7'h1 : volTarget) :
    rampUp ? (riseRamp ? curVol_q - 7'h1 : volTarget) :
    curVol_q;

  // ==================================================
  // Sample-rate band.
  // ==================================================
  // The gap counts idle cycles, so a spacing of n reads as n here.
  wire [1:0] filtNext =
    (gap_q < 16'(sgl_pkg::RATE_HI_CYC)) ? 2'h2 :
    (gap_q < 16'(sgl_pkg::RATE_MID_CYC)) ? 2'h1 : 2'h0;

  // ==================================================
  // Register writes.
  // ==================================================
  // Safe mode comes out of reset set so a speaker is protected.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= sgl_pkg::CTRL_RST;
      vol_q <= sgl_pkg::VOL_RST;
      scale_q <= sgl_pkg::GAIN_RST;
      margin_q <= sgl_pkg::MARGIN_RST;
      cap_q <= sgl_pkg::CAP_RST;
    end else if (wrEn) begin
      if (hitCtrl) begin
        ctrl_q <= pwdata[5:0];
      end
      if (hitVol) begin
        vol_q <= pwdata[6:0];
      end
      if (hitGain) begin
        scale_q <= pwdata[3:0];
      end
      if (hitTrack) begin
        margin_q <= marginWr;
        cap_q <= capWr;
      end
    end
  end

  // Read data is captured in the setup phase so that it comes
  // from a flop and is steady through the access phase.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0 : rdMux;
    end
  end

  // ==================================================
  // Engaged flag.
  // ==================================================
  // A new engagement in the clearing cycle wins over the clear.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sticky_q <= 1'b0;
    end else if (sampleValid && limEngaged) begin
      sticky_q <= 1'b1;
    end else if (statRead) begin
      sticky_q <= 1'b0;
    end
  end

  // Live flag follows the latest sample.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      live_q <= 1'b0;
    end else if (sampleValid) begin
      live_q <= limEngaged;
    end
  end

  // ==================================================
  // Supply reading.
  // ==================================================
  // A zero reading until the measurement arrives looks like no
  // supply; software arms the measurement first.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      supply_q <= '0;
    end else if (supplyValid) begin
      supply_q <= supplyCode;
    end
  end

  // ==================================================
  // Sample path.
  // ==================================================
  // Volume moves one step per sample while ramping.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      curVol_q <= sgl_pkg::VOL_MUTE;
    end else if (sampleValid) begin
      curVol_q <= volNext;
    end
  end

  // One output sample per input sample, one cycle later.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      outValid_q <= 1'b0;
      sampleOut_q <= '0;
    end else begin
      outValid_q <= sampleValid;
      if (sampleValid) begin
        sampleOut_q <= muted ? '0 : satOut;
      end
    end
  end

  // Analog share: 2 dB steps above the 6 dB floor.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      analog_q <= 3'h0;
    end else begin
      analog_q <= safeOn ? 3'h0 : scale_q[3:1];
    end
  end

  // ==================================================
  // Sample interval measurement.
  // ==================================================
  // The gap counter saturates so a stopped stream reads slow.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 16'h0;
      filt_q <= 2'h0;
    end else if (sampleValid) begin
      gap_q <= 16'h0;
      filt_q <= filtNext;
    end else if (gap_q != 16'hFFFF) begin
      gap_q <= gap_q + 16'h1;
    end
  end

  // ==================================================
  // Output ports.
  // ==================================================
  // Every data output is a flop, so nothing here glitches.
  assign outValid = outValid_q;
  assign sampleOut = sampleOut_q;
  assign analogGainCode = analog_q;
  assign dacFilterSel = filt_q;
  assign limiterActive = live_q;

endmodule // sgl_limiter

/* verification/sgl_monitor.sv */
// Port checker for the speaker limiter, bound into sgl_limiter.
// Assumes every APB write completes in its first access cycle.
`timescale 1ns/1ps
module sgl_monitor #(
  parameter int SAMPLE_W = 24
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic sampleValid,
  input wire logic [SAMPLE_W-1:0] sampleIn,
  input wire logic outValid,
  input wire logic [SAMPLE_W-1:0] sampleOut,
  input wire logic [2:0] analogGainCode,
  input wire logic [1:0] dacFilterSel,
  input wire logic limiterActive
);
  // ==========
  // Register mirror
  // ==========
  logic [5:0] ctrlQ; // Control word as software last wrote it.
  logic [3:0] gainQ; // Scaling code as software last wrote it.
  wire wrEn = psel && penable && pwrite; // A write lands at this edge.
  // Tracker off, or the unbuilt fixed-level mode, means no attenuation.
  wire noTrack = !ctrlQ[sgl_pkg::CTRL_TRACK] || ctrlQ[sgl_pkg::CTRL_MODE];
  // Only fields whose effect shows at the ports are mirrored.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlQ <= sgl_pkg::CTRL_RST;
      gainQ <= sgl_pkg::GAIN_RST;
    end else if (wrEn && paddr == sgl_pkg::OFS_CTRL) begin
      ctrlQ <= pwdata[5:0];
    end else if (wrEn && paddr == sgl_pkg::OFS_GAIN) begin
      gainQ <= pwdata[3:0];
    end
  end
  // ==========
  // Assertions
  // ==========
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  AST_OUT_PAIR: assert property (sampleValid |=> outValid)
    else $error("no output one cycle after a sample");
  AST_OUT_CAUSE: assert property (outValid |-> $past(sampleValid))
    else $error("output without an input sample");
  AST_OUT_HOLD: assert property (!sampleValid |=> $stable(sampleOut))
    else $error("output sample changed between samples");
  AST_ZERO_IN: assert property (sampleValid && sampleIn == '0 |=>
    sampleOut == '0) else $error("silence did not stay silent");
  // Skip the cycle in which the mirrored bit itself changes.
  AST_SAFE_ANALOG: assert property (
    ctrlQ[0] && $past(ctrlQ[0]) |-> analogGainCode == 3'h0)
    else $error("analog gain not at minimum in safe mode");
  AST_GAIN_SPLIT: assert property (
    !ctrlQ[0] && !$past(ctrlQ[0]) && $stable(gainQ)
    |-> analogGainCode == gainQ[3:1])
    else $error("analog gain does not follow the scaling code");
  AST_TRACK_OFF: assert property (noTrack && sampleValid |=>
    !limiterActive) else $error("limiter engaged while disabled");
  AST_DAC_SEL: assert property (!sampleValid |=>
    $stable(dacFilterSel) && dacFilterSel != 2'h3)
    else $error("filter select moved between samples or left its bands");
endmodule // sgl_monitor

/* verification/sgl_pcm_source.sv */
// Model of the PCM receiver and mixer feeding mono samples.
// Assumes the bench sets run, spacing and level between edges.
`timescale 1ns/1ps
module sgl_pcm_source (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [15:0] spacing,
  input wire logic [23:0] level,
  output logic sampleValid,
  output logic [23:0] sampleIn
);
  // ==========
  // Frame pacing
  // ==========
  logic [15:0] cntQ; // Cycles left until the next frame.
  // One sample every spacing+1 cycles while run is high.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cntQ <= 16'h0000;
      sampleValid <= 1'b0;
      sampleIn <= 24'h000000;
    end else if (run && cntQ == 16'h0000) begin
      cntQ <= spacing;
      sampleValid <= 1'b1;
      sampleIn <= level;
    end else begin
      cntQ <= run ? cntQ - 16'h0001 : 16'h0000;
      sampleValid <= 1'b0;
      // No word between frames, so the line is inverted every cycle, not held.
      sampleIn <= ~sampleIn;
    end
  end
endmodule // sgl_pcm_source

/* verification/testbench.sv */
// Self-checking bench for the speaker gain and headroom limiter.
// Assumes sgl_pkg, sgl_limiter, sgl_pcm_source and sgl_monitor.
`timescale 1ns/1ps
module testbench;
  // ==========
  // Signals
  // ==========
  logic mclk, reset_n, psel, penable, pwrite, supplyValid, run, act;
  logic pready, pslverr, rerr, sampleValid, outValid, limiterActive;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [23:0] sampleIn, sampleOut, level, got;
  logic [15:0] supplyCode, spacing;
  logic [2:0] analogGainCode;
  logic [1:0] dacFilterSel;
  int mismatches = 0;
  int totalChecks = 0;
  sgl_limiter sgl_limiter_inst (.mclk(mclk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleValid(sampleValid), .sampleIn(sampleIn),
    .supplyValid(supplyValid), .supplyCode(supplyCode),
    .outValid(outValid), .sampleOut(sampleOut),
    .analogGainCode(analogGainCode), .dacFilterSel(dacFilterSel),
    .limiterActive(limiterActive));
  sgl_pcm_source sgl_pcm_source_inst (.mclk(mclk), .reset_n(reset_n),
    .run(run), .spacing(spacing), .level(level),
    .sampleValid(sampleValid), .sampleIn(sampleIn));
  // ==========
  // Shared tasks
  // ==========
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // A wait that ran out counts as a mismatch and ends the run.
  task automatic hang();
    mismatches++;
    completeRun();
  endtask
  // One APB transfer; psel idles a cycle so no signal is set twice.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // The model sends one sample; its answer is taken at outValid.
  task automatic sendOne(input logic [23:0] v);
    int n;
    @(posedge mclk);
    level <= v;
    run <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (outValid !== 1'b1 && n < 50);
    if (n >= 50) hang();
    got = sampleOut;
    act = limiterActive;
    run <= 1'b0;
  endtask
  task automatic supply(input logic [15:0] mv);
    @(posedge mclk);
    supplyValid <= 1'b1;
    supplyCode <= mv;
    @(posedge mclk);
    supplyValid <= 1'b0;
  endtask
  // The log math is approximate, so about 0.7 dB of slack is allowed.
  task automatic expectOut(input int x, input real db);
    int e;
    int d;
    e = $rtoi(x * 10.0 ** (db / 20.0));
    d = int'($signed(got)) - e;
    check((d * 12 <= e && -d * 12 <= e) ? e : {8'h00, got}, e);
  endtask
  task automatic volIs(input logic [6:0] e);
    apb(1'b0, 8'h10, 32'h0);
    check({25'h0, rdata[14:8]}, {25'h0, e});
  endtask
  // ==========
  // Scenarios
  // ==========
  task automatic testReset();
    logic [7:0] adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] val [6] = '{32'h1, 32'h0, 32'h0, 32'hE08, 32'h7F00,
                             32'h0};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, adr[i], 32'h0);
      check(rdata, val[i]);
      check({31'h0, rerr}, {31'h0, i == 5});
    end
    $display("reset values test done");
  endtask
  task automatic testSafe();
    apb(1'b1, 8'h00, 32'h21);
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b1, 8'h04, 32'h20);
    sendOne(24'h400000);
    expectOut(32'h400000, -18.0);
    check({29'h0, analogGainCode}, 32'h0);
    apb(1'b1, 8'h04, 32'h7F);
    sendOne(24'h400000);
    expectOut(32'h400000, -18.0);
    $display("safe mode test done");
  endtask
  task automatic testGain();
    apb(1'b1, 8'h00, 32'h20);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 8'h08, c);
      repeat (2) @(posedge mclk);
      check({29'h0, analogGainCode}, c / 2);
    end
    apb(1'b1, 8'h08, 32'h3);
    apb(1'b1, 8'h04, 32'hC);
    // A new volume code takes hold from the second sample after the write on.
    sendOne(24'h100000);
    sendOne(24'h100000);
    expectOut(32'h100000, 1.0 - 6.0);
    volIs(7'h0C);
    sendOne(24'h000000);
    check({8'h0, got}, 32'h0);
    apb(1'b1, 8'h04, 32'h7F);
    sendOne(24'h100000);
    sendOne(24'h100000);
    check({8'h0, got}, 32'h0);
    $display("gain and volume test done");
  endtask
  task automatic testRamp();
    apb(1'b1, 8'h00, 32'h22);
    apb(1'b1, 8'h04, 32'h0);
    sendOne(24'h100000);
    volIs(7'h7E);
    apb(1'b1, 8'h00, 32'h24);
    sendOne(24'h100000);
    volIs(7'h00);
    apb(1'b1, 8'h04, 32'h7F);
    sendOne(24'h100000);
    volIs(7'h01);
    $display("volume ramp test done");
  endtask
  task automatic testTrack();
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h20);
    sendOne(24'h100000);
    supply(16'h0FA0);
    apb(1'b1, 8'h0C, 32'hE08);
    apb(1'b1, 8'h00, 32'h28);
    sendOne(24'h7FFFFF);
    expectOut(32'h7FFFFF, 0.0);
    check({31'h0, act}, 32'h0);
    supply(16'h03E8);
    sendOne(24'h100000);
    expectOut(32'h100000, 0.0);
    sendOne(24'h7FFFFF);
    expectOut(32'h7FFFFF, -6.48);
    check({31'h0, act}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check({30'h0, rdata[1:0]}, 32'h3);
    apb(1'b0, 8'h10, 32'h0);
    check({30'h0, rdata[1:0]}, 32'h2);
    apb(1'b1, 8'h0C, 32'hE00);
    sendOne(24'h7FFFFF);
    expectOut(32'h7FFFFF, 20.0 * $log10(0.8) - 6.48);
    apb(1'b1, 8'h0C, 32'h300);
    sendOne(24'h7FFFFF);
    expectOut(32'h7FFFFF, -4.0);
    apb(1'b1, 8'h00, 32'h38);
    sendOne(24'h7FFFFF);
    expectOut(32'h7FFFFF, 0.0);
    apb(1'b1, 8'h00, 32'h28);
    sendOne(24'h100000);
    check({31'h0, act}, 32'h0);
    apb(1'b1, 8'h00, 32'h20);
    sendOne(24'h7FFFFF);
    expectOut(32'h7FFFFF, 0.0);
    $display("headroom tracker test done");
  endtask
  // Three samples at one spacing let the rate detector settle.
  task automatic filt(input logic [15:0] sp, input logic [1:0] e);
    int n;
    int k;
    @(posedge mclk);
    spacing <= sp;
    run <= 1'b1;
    n = 0;
    k = 0;
    while (k < 3 && n < 20000) begin
      @(posedge mclk);
      n++;
      if (outValid === 1'b1) k++;
    end
    if (k < 3) hang();
    run <= 1'b0;
    repeat (2) @(posedge mclk);
    check({30'h0, dacFilterSel}, {30'h0, e});
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========
  // Clock and main sequence
  // ==========
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, supplyValid, run} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    supplyCode = 16'h0000;
    spacing = 16'h0028;
    level = 24'h000000;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    testReset();
    testSafe();
    testGain();
    testRamp();
    testTrack();
    filt(16'h0063, 2'h2);
    filt(16'h0BB7, 2'h1);
    filt(16'h1387, 2'h0);
    $display("filter select test done");
    completeRun();
  end
endmodule // testbench
bind sgl_limiter sgl_monitor #(.SAMPLE_W(SAMPLE_W)) sgl_monitor_inst (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .sampleValid(sampleValid), .sampleIn(sampleIn), .outValid(outValid),
  .sampleOut(sampleOut), .analogGainCode(analogGainCode),
  .dacFilterSel(dacFilterSel), .limiterActive(limiterActive));
